// file: design/fst_counter.sv
// down counter: loads a length, pulses done on its last count, while it holds one
// assumes load and length from the same clock
`timescale 1ns/10ps
module fst_counter #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] len_i,
  output logic              busy_o,
  output logic              done_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         run;
  logic         next_run;

  // ---------------------------------------------------------------
  // count; a zero length still lasts one cycle
  // ---------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_run = run;
    if (load_i) begin
      next_cnt = (len_i == '0) ? W'(1) : len_i;
      next_run = 1'b1;
    end else if (run) begin
      next_cnt = cnt - W'(1);
      if (cnt == W'(1)) next_run = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      run <= 1'b0;
    end else begin
      cnt <= next_cnt;
      run <= next_run;
    end
  end

  assign busy_o = run;
  assign done_o = run & (cnt == W'(1)) & ~load_i;
endmodule

// file: design/fst_pkg.sv
// frame start trigger control: shared constants, register map and types
// assumes an apb slave at 32-bit data, one clock at 200 MHz
//
// What this block does
// [R1] host issues one software trigger command per frame it wants
// [R2] while waiting, a software trigger starts exposure at once
// [R3] accepted software trigger clears waiting; waiting returns when ready again
// [R4] software source uses timed exposure with the programmed duration
// [R5] software triggers arriving while not waiting are dropped silently; here they also set the over event
// [R6] host keeps software trigger rate within the allowed frame rate
// [R7] with line 1 or 2 selected, that line is the trigger
// [R8] polarity setting picks rising or falling edge as trigger
// [R9] every selected edge while waiting starts one acquisition
// [R10] accepted hardware edge clears waiting; restored when ready again
// [R11] one acquisition per accepted edge, rate follows trigger period
// [R12] edges arriving while not waiting are ignored, no acquisition; here they also set the over event
// [R13] external source keeps edge rate within the allowed frame rate
// [R14] software trigger reaches frame start only when target is frame start
// [R15] rate limit disabled means no internal pacing of acquisitions
// [R16] reset selects line 1 for frame start, line 2 for acquisition start
// [R17] triggering off means frame starts are generated internally
// [R18] each line is synchronised by two flops, edge gives one-cycle pulse
package fst_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] EXPO_OFS   = 8'h08;
  localparam logic [7:0] PERIOD_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS   = 8'h10;
  localparam logic [7:0] IRQ_OFS    = 8'h14;
  localparam logic [7:0] MASK_OFS   = 8'h18;
  localparam logic [7:0] READY_OFS  = 8'h1c;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_BIT  = 0;   // frame start triggering on
  localparam int CTRL_POL_BIT   = 1;   // 1 = falling edge
  localparam int CTRL_LIMIT_BIT = 2;   // internal rate limit enable
  localparam int CTRL_ACQ_BIT   = 3;   // acquisition running
  localparam int CTRL_TGT_LSB   = 4;   // trigger target select
  localparam int CTRL_FS_LSB    = 8;   // frame start origin
  localparam int CTRL_AS_LSB    = 10;  // acquisition start origin
  localparam int CMD_SW_BIT     = 0;   // software trigger command

  // event bits of status/mask registers
  localparam int EV_FRAME_BIT = 0;
  localparam int EV_OVER_BIT  = 1;
  localparam int EV_DONE_BIT  = 2;
  localparam int EV_W         = 3;

  // trigger origin and target encodings
  localparam logic [1:0] ORG_SW    = 2'h0;
  localparam logic [1:0] ORG_LINE1 = 2'h1;
  localparam logic [1:0] ORG_LINE2 = 2'h2;
  localparam logic [1:0] TGT_FRAME = 2'h1;
  localparam logic [1:0] TGT_ACQ   = 2'h0;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0900; // fs=line1, as=line2
  localparam logic [31:0] EXPO_RST   = 32'h0000_0064;
  localparam logic [31:0] PERIOD_RST = 32'h0000_03e8;
  localparam logic [31:0] READY_RST  = 32'h0000_0010; // readout after exposure

  typedef enum logic [1:0] {FST_WAIT, FST_EXPOSE, FST_READOUT, FST_IDLE} fst_state_t;
endpackage

// file: design/fst_sync_edge.sv
// two-flop synchroniser plus edge detector for one trigger line
// assumes the line is asynchronous to clk_i
`timescale 1ns/10ps
module fst_sync_edge (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic line_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic last;

  // ---------------------------------------------------------------
  // synchroniser; meta feeds sync only
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= line_i;
      sync <= meta;   // [R18]
      last <= sync;
    end
  end

  // one-cycle pulses from the synchronised level
  assign rise_o = sync & ~last;   // [R18]
  assign fall_o = ~sync & last;   // [R18]
endmodule

// file: design/fst_top.sv
// frame start trigger control with apb register file
// assumes apb master on MCLK_I, trigger lines asynchronous
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module fst_top (
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        LINE1_I,
  input  wire logic        LINE2_I,
  output logic             EXPOSE_O,
  output logic             WAITING_O,
  output logic             FRAME_START_O,
  output logic             IRQ_O
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  localparam int EV_W = fst_pkg::EV_W;

  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] expo;
  logic [31:0] next_expo;
  logic [31:0] period;
  logic [31:0] next_period;
  logic [31:0] ready_len;
  logic [31:0] next_ready_len;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] next_irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] next_irq_mask;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic        pready;
  logic        next_pready;
  logic        pslverr;
  logic        next_pslverr;

  logic wr_en;
  logic rd_en;
  logic sw_cmd;
  logic l1_rise;
  logic l1_fall;
  logic l2_rise;
  logic l2_fall;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == fst_pkg::CTRL_OFS) || (a == fst_pkg::CMD_OFS) ||
                 (a == fst_pkg::EXPO_OFS) || (a == fst_pkg::PERIOD_OFS) ||
                 (a == fst_pkg::STAT_OFS) || (a == fst_pkg::IRQ_OFS) ||
                 (a == fst_pkg::MASK_OFS) || (a == fst_pkg::READY_OFS);
  endfunction

  // access phase answered in one cycle: pready rises on the second edge
  // writes land at the edge where pready is sampled high, so a master
  // that drops the request early never changes a register
  // reads load prdata one edge earlier so it stands together with pready
  assign wr_en  = PSEL_I & PENABLE_I & PWRITE_I & pready;
  assign rd_en  = PSEL_I & PENABLE_I & ~PWRITE_I & ~pready;
  assign sw_cmd = wr_en & (PADDR_I == fst_pkg::CMD_OFS) & PWDATA_I[fst_pkg::CMD_SW_BIT];

  // ---------------------------------------------------------------
  // trigger line synchronisers
  // ---------------------------------------------------------------
  // pin to frame start is about three cycles: two sync flops, then the
  // frame start output flop; pulses shorter than one cycle may be lost
  fst_sync_edge u_sync1 (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .line_i  (LINE1_I),
    .rise_o  (l1_rise),
    .fall_o  (l1_fall)
  );

  fst_sync_edge u_sync2 (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .line_i  (LINE2_I),
    .rise_o  (l2_rise),
    .fall_o  (l2_fall)
  );

  // ---------------------------------------------------------------
  // trigger selection
  // ---------------------------------------------------------------
  logic       trig_on;
  logic       falling;
  logic       limit_en;
  logic       acq_run;
  logic [1:0] fs_org;
  logic [1:0] target;
  logic       hw_edge;
  logic       sw_trig;
  logic       ext_trig;
  logic       int_trig;
  logic       any_trig;

  assign trig_on  = ctrl[fst_pkg::CTRL_MODE_BIT];
  assign falling  = ctrl[fst_pkg::CTRL_POL_BIT];
  assign limit_en = ctrl[fst_pkg::CTRL_LIMIT_BIT];
  assign acq_run  = ctrl[fst_pkg::CTRL_ACQ_BIT];
  assign fs_org   = ctrl[fst_pkg::CTRL_FS_LSB +: 2];
  assign target   = ctrl[fst_pkg::CTRL_TGT_LSB +: 2];

  // polarity picks the edge of the chosen line
  always_comb begin
    case (fs_org)
      fst_pkg::ORG_LINE1: hw_edge = falling ? l1_fall : l1_rise;   // [R7] [R8]
      fst_pkg::ORG_LINE2: hw_edge = falling ? l2_fall : l2_rise;   // [R7] [R8]
      default:            hw_edge = 1'b0;
    endcase
  end

  // command counts only while the target is frame start
  assign sw_trig  = trig_on & (fs_org == fst_pkg::ORG_SW) & sw_cmd &
                    (target == fst_pkg::TGT_FRAME);   // [R14]
  assign ext_trig = trig_on & (fs_org != fst_pkg::ORG_SW) & hw_edge;

  // ---------------------------------------------------------------
  // internal pacing for free-running mode
  // ---------------------------------------------------------------
  logic        pace_busy;
  logic        frame_go;

  // pacing needs only busy: feeding the pulse back into the trigger path
  // would loop through load, so the pulse output stays open
  fst_counter #(.W(32)) u_pace (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .load_i  (frame_go & limit_en),
    .len_i   (period),
    .busy_o  (pace_busy),
    .done_o  ()
  );

  // without the limit, next frame starts as soon as waiting again
  assign int_trig = ~trig_on & acq_run & (~limit_en | ~pace_busy);   // [R17] [R15]
  assign any_trig = sw_trig | ext_trig | int_trig;

  // ---------------------------------------------------------------
  // acquisition sequencer
  // ---------------------------------------------------------------
  fst_pkg::fst_state_t state;
  fst_pkg::fst_state_t next_state;
  logic        exp_busy;
  logic        exp_done;
  logic        rdo_busy;
  logic        rdo_done;
  logic        rdo_go;
  logic        over;

  fst_counter #(.W(32)) u_expo (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .load_i  (frame_go),
    .len_i   (expo),            // [R4]
    .busy_o  (exp_busy),
    .done_o  (exp_done)
  );

  fst_counter #(.W(32)) u_rdo (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .load_i  (rdo_go),
    .len_i   (ready_len),
    .busy_o  (rdo_busy),
    .done_o  (rdo_done)
  );

  assign frame_go = (state == fst_pkg::FST_WAIT) & any_trig;   // [R2] [R9] [R11]
  assign rdo_go   = (state == fst_pkg::FST_EXPOSE) & exp_done;
  // software and line triggers outside waiting are dropped and flagged only
  assign over     = (state != fst_pkg::FST_WAIT) & (sw_trig | ext_trig);   // [R5] [R12]

  // waiting is left only on an accepted trigger and comes back after
  // readout, so no trigger can be taken in the middle of a frame
  always_comb begin
    next_state = state;
    case (state)
      fst_pkg::FST_WAIT:    if (any_trig) next_state = fst_pkg::FST_EXPOSE;   // [R3] [R10]
      fst_pkg::FST_EXPOSE:  if (exp_done) next_state = fst_pkg::FST_READOUT;
      fst_pkg::FST_READOUT: if (rdo_done) next_state = fst_pkg::FST_WAIT;     // [R3] [R10]
      default:              next_state = fst_pkg::FST_WAIT;
    endcase
  end

  // reset lands in waiting; the registered outputs follow at the first edge
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= fst_pkg::FST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // register writes, sticky events, read mux
  // ---------------------------------------------------------------
  logic [EV_W-1:0] ev;

  // event bits placed by their package positions
  always_comb begin
    ev                        = '0;
    ev[fst_pkg::EV_FRAME_BIT] = frame_go;
    ev[fst_pkg::EV_OVER_BIT]  = over;
    ev[fst_pkg::EV_DONE_BIT]  = rdo_done;
  end

  always_comb begin
    next_ctrl      = ctrl;
    next_expo      = expo;
    next_period    = period;
    next_ready_len = ready_len;
    next_irq_mask  = irq_mask;
    next_irq_stat  = irq_stat;
    next_pready    = PSEL_I & PENABLE_I & ~pready;
    next_pslverr   = PSEL_I & PENABLE_I & ~pready & ~known_addr(PADDR_I);
    next_prdata    = prdata;
    if (wr_en) begin
      case (PADDR_I)
        fst_pkg::CTRL_OFS:   next_ctrl      = PWDATA_I;
        fst_pkg::EXPO_OFS:   next_expo      = PWDATA_I;
        fst_pkg::PERIOD_OFS: next_period    = PWDATA_I;
        fst_pkg::READY_OFS:  next_ready_len = PWDATA_I;
        fst_pkg::MASK_OFS:   next_irq_mask  = PWDATA_I[EV_W-1:0];
        fst_pkg::IRQ_OFS:    next_irq_stat  = irq_stat & ~PWDATA_I[EV_W-1:0];
        default:             next_ctrl      = ctrl;
      endcase
    end
    next_irq_stat = next_irq_stat | ev;   // set wins over clear
    if (rd_en) begin
      case (PADDR_I)
        fst_pkg::CTRL_OFS:   next_prdata = ctrl;
        fst_pkg::EXPO_OFS:   next_prdata = expo;
        fst_pkg::PERIOD_OFS: next_prdata = period;
        fst_pkg::READY_OFS:  next_prdata = ready_len;
        fst_pkg::STAT_OFS:   next_prdata = {29'h0, rdo_busy, exp_busy, state == fst_pkg::FST_WAIT};
        fst_pkg::IRQ_OFS:    next_prdata = {29'h0, irq_stat};
        fst_pkg::MASK_OFS:   next_prdata = {29'h0, irq_mask};
        default:             next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl      <= fst_pkg::CTRL_RST;   // [R16]
      expo      <= fst_pkg::EXPO_RST;
      period    <= fst_pkg::PERIOD_RST;
      ready_len <= fst_pkg::READY_RST;
      irq_mask  <= '0;
      irq_stat  <= '0;
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      expo      <= next_expo;
      period    <= next_period;
      ready_len <= next_ready_len;
      irq_mask  <= next_irq_mask;
      irq_stat  <= next_irq_stat;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic expose_q;
  logic waiting_q;
  logic start_q;
  logic irq_q;

  // decoded from next values so each output lines up with the state flop;
  // costs one gate level ahead of the output flops
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      expose_q  <= 1'b0;
      waiting_q <= 1'b0;
      start_q   <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      expose_q  <= (next_state == fst_pkg::FST_EXPOSE);
      waiting_q <= (next_state == fst_pkg::FST_WAIT);
      start_q   <= frame_go;
      irq_q     <= |(next_irq_stat & next_irq_mask);
    end
  end

  assign EXPOSE_O      = expose_q;
  assign WAITING_O     = waiting_q;
  assign FRAME_START_O = start_q;
  assign IRQ_O         = irq_q;
  assign PRDATA_O      = prdata;
  assign PREADY_O      = pready;
  assign PSLVERR_O     = pslverr;
endmodule

// file: tb/frame_start_trigger_control_test.sv
// ---------------------------------------------------------------
// frame start trigger control bench
// ---------------------------------------------------------------
// apb host, two trigger sources and a frame model checking the top
// assumes fst_pkg, fst_top, fst_line_src and fst_chk compiled first
`timescale 1ns/10ps
module frame_start_trigger_control_test;
  logic        mclk, resetn, psel, pen, pwr, sl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, slverr, l1, l2, expose, waiting, fs, irq;
  int          bad_count, compares, seed, cyc, fs_cnt, elen, exp_fs, m_free, expo, rdy, c, c1, c2;
  logic        m_ovr;
  int          lenq[$];
  logic [7:0]  ofs[4] = '{fst_pkg::CTRL_OFS, fst_pkg::EXPO_OFS, fst_pkg::PERIOD_OFS, fst_pkg::READY_OFS};
  logic [31:0] rv[4]  = '{fst_pkg::CTRL_RST, fst_pkg::EXPO_RST, fst_pkg::PERIOD_RST, fst_pkg::READY_RST};

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  fst_top i_dut (.MCLK_I(mclk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(slverr),
    .LINE1_I(l1), .LINE2_I(l2), .EXPOSE_O(expose), .WAITING_O(waiting), .FRAME_START_O(fs), .IRQ_O(irq));
  fst_line_src i_l1 (.line_o(l1));
  fst_line_src i_l2 (.line_o(l2));

  // monitor: cycle time, frame count, exposure lengths
  always @(posedge mclk) begin
    cyc++;
    if (fs === 1'b1) fs_cnt++;
    if (expose === 1'b1) elen++;
    else if (elen > 0) begin
      lenq.push_back(elen);
      elen = 0;
    end
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      bad_count++;
      give_verdict();
    end
    rd = prdata;
    sl = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask

  // frame model: a routed trigger is taken only when the model is free
  task automatic trig();
    if (cyc >= m_free) begin
      exp_fs++;
      m_free = cyc + expo + rdy + 4;
    end else
      m_ovr = 1'b1;
  endtask

  // wait until model and design are both ready for a trigger
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge mclk);
    while ((waiting !== 1'b1 || cyc < m_free) && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) begin
      chk(32'h0, 32'h1, "waiting never restored");
      give_verdict();
    end
  endtask

  task automatic pulses(input int ln, input logic act, input int n, input bit routed);
    repeat (n) begin
      @(posedge mclk);
      if (ln == 1) i_l1.set_lvl(act);
      else i_l2.set_lvl(act);
      if (routed) trig();
      repeat (3) @(posedge mclk);
      if (ln == 1) i_l1.set_lvl(~act);
      else i_l2.set_lvl(~act);
    end
  endtask

  function automatic logic [31:0] ctl(input logic m, p, lim, input logic [1:0] tg, org);
    ctl = (32'(m) << fst_pkg::CTRL_MODE_BIT) | (32'(p) << fst_pkg::CTRL_POL_BIT) |
          (32'(lim) << fst_pkg::CTRL_LIMIT_BIT) | (32'h1 << fst_pkg::CTRL_ACQ_BIT) |
          (32'(tg) << fst_pkg::CTRL_TGT_LSB) | (32'(org) << fst_pkg::CTRL_FS_LSB);
  endfunction

  task automatic irq_check(input string what);
    apb(1'b0, fst_pkg::IRQ_OFS, 32'h0);
    chk(32'(rd[fst_pkg::EV_OVER_BIT]), 32'(m_ovr), what);
    chk(32'(irq), 32'(m_ovr), "irq level");
    apb(1'b1, fst_pkg::IRQ_OFS, 32'h7);
    apb(1'b0, fst_pkg::IRQ_OFS, 32'h0);
    chk(rd, 32'h0, "irq cleared");
    m_ovr = 1'b0;
  endtask

  initial begin
    #400us;
    chk(32'h0, 32'h1, "watchdog");
    give_verdict();
  end

  // main sequence
  initial begin
    {psel, pen, pwr, paddr, pwdata, m_ovr} = '0;
    seed = 28667;
    resetn = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rv[i], "reset value");
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], sl}, 32'h1, "unmapped read");
    $display("test reset values done");
    expo = 8 + ($unsigned($random(seed)) % 32);
    rdy = 2 + ($unsigned($random(seed)) % 16);
    apb(1'b1, fst_pkg::EXPO_OFS, 32'(expo));
    apb(1'b1, fst_pkg::READY_OFS, 32'(rdy));
    apb(1'b1, fst_pkg::MASK_OFS, 32'h2);
    // software trigger aimed at acquisition start must not start a frame
    apb(1'b1, fst_pkg::CTRL_OFS, ctl(1'b1, 1'b0, 1'b0, fst_pkg::TGT_ACQ, fst_pkg::ORG_SW));
    apb(1'b1, fst_pkg::CMD_OFS, 32'h1);
    settle();
    chk(32'(fs_cnt), 32'(exp_fs), "sw trigger off target");
    apb(1'b1, fst_pkg::CTRL_OFS, ctl(1'b1, 1'b0, 1'b0, fst_pkg::TGT_FRAME, fst_pkg::ORG_SW));
    lenq.delete();
    apb(1'b1, fst_pkg::CMD_OFS, 32'h1);
    trig();
    apb(1'b1, fst_pkg::CMD_OFS, 32'h1);
    trig();
    settle();
    chk(32'(fs_cnt), 32'(exp_fs), "sw frames");
    chk(lenq.size() > 0 ? 32'(lenq[0]) : 32'h0, 32'(expo), "exposure length");
    irq_check("sw overtrigger");
    $display("test software trigger done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, fst_pkg::CTRL_OFS, ctl(1'b1, k[1], 1'b0, fst_pkg::TGT_FRAME, fst_pkg::ORG_SW));
      i_l1.set_lvl(k[1]);
      i_l2.set_lvl(k[1]);
      @(posedge mclk); // bus signals change only right after an edge
      apb(1'b1, fst_pkg::CTRL_OFS, ctl(1'b1, k[1], 1'b0, fst_pkg::TGT_FRAME, 2'(k[0] + 1)));
      pulses(2 - k[0], ~k[1], 1, 1'b0);
      pulses(1 + k[0], ~k[1], 2, 1'b1);
      settle();
      pulses(1 + k[0], ~k[1], 1, 1'b1);
      settle();
      chk(32'(fs_cnt), 32'(exp_fs), "hw frames");
      irq_check("hw overtrigger");
    end
    $display("test hardware trigger done");
    apb(1'b1, fst_pkg::CTRL_OFS, ctl(1'b0, 1'b0, 1'b0, fst_pkg::TGT_FRAME, fst_pkg::ORG_SW));
    c = fs_cnt;
    repeat (600) @(posedge mclk);
    c1 = fs_cnt - c;
    apb(1'b1, fst_pkg::PERIOD_OFS, 32'd200);
    apb(1'b1, fst_pkg::CTRL_OFS, ctl(1'b0, 1'b0, 1'b1, fst_pkg::TGT_FRAME, fst_pkg::ORG_SW));
    c = fs_cnt;
    repeat (600) @(posedge mclk);
    c2 = fs_cnt - c;
    chk(32'(c1 >= 2), 32'h1, "internal frames");
    chk(32'(c2 < c1 && c2 <= 4), 32'h1, "paced frames");
    $display("test internal frames done");
    give_verdict();
  end
endmodule

// file: tb/fst_line_src.sv
// ---------------------------------------------------------------
// external trigger source model
// ---------------------------------------------------------------
// drives one trigger line, asynchronous to the block clock
// assumes the bench asks for each level change by task call
`timescale 1ns/10ps
module fst_line_src #(
  parameter real MIN_NS = 12.0
) (
  output logic line_o
);
  realtime last;

  initial begin
    line_o = 1'b0;
    last = 0;
  end

  // hold each level long enough for the two-flop sampler to see it
  task automatic set_lvl(input logic v);
    if ($realtime - last < MIN_NS) #(MIN_NS - ($realtime - last));
    #1.2 line_o = v; // off the clock grid on purpose
    last = $realtime;
  endtask
endmodule

// file: tb/fst_top_chk.sv
// ---------------------------------------------------------------
// checker for the frame start trigger control top
// ---------------------------------------------------------------
// holds concurrent checks on the top ports only
// assumes one clock domain, reset async active low
`timescale 1ns/10ps
module fst_chk (
  input wire logic        MCLK_I,
  input wire logic        RESETN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        LINE1_I,
  input wire logic        LINE2_I,
  input wire logic        EXPOSE_O,
  input wire logic        WAITING_O,
  input wire logic        FRAME_START_O,
  input wire logic        IRQ_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);

  // frame start side: one pulse, only from the waiting status
  AST_FS_ONE_CYCLE: assert property (FRAME_START_O |=> !FRAME_START_O)
    else $error("frame start pulse longer than one cycle");
  AST_FS_NEEDS_WAIT: assert property (FRAME_START_O |-> $past(WAITING_O))
    else $error("frame started while not waiting");
  AST_FS_CLEARS_WAIT: assert property (FRAME_START_O |-> !WAITING_O && EXPOSE_O)
    else $error("frame start without exposure or with waiting kept");
  AST_WAIT_FALL_CAUSE: assert property ($fell(WAITING_O) |-> FRAME_START_O)
    else $error("waiting left without a frame start");
  AST_WAIT_RETURNS: assert property ($fell(WAITING_O) |-> ##[1:1000] WAITING_O)
    else $error("waiting status not restored");
  AST_EXPOSE_NOT_WAIT: assert property (EXPOSE_O |-> !WAITING_O)
    else $error("waiting while exposing");

  // register bus side: one ready pulse, one cycle after the access edge
  AST_READY_TIMING: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I) |=> PREADY_O)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (PREADY_O |-> PSEL_I && PENABLE_I ##1 !PREADY_O)
    else $error("ready outside access or held");
  AST_ERR_WITH_READY: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error response without ready");
endmodule
bind fst_top fst_chk i_chk (
  .MCLK_I        (MCLK_I),
  .RESETN_I      (RESETN_I),
  .PSEL_I        (PSEL_I),
  .PENABLE_I     (PENABLE_I),
  .PWRITE_I      (PWRITE_I),
  .PADDR_I       (PADDR_I),
  .PWDATA_I      (PWDATA_I),
  .PRDATA_O      (PRDATA_O),
  .PREADY_O      (PREADY_O),
  .PSLVERR_O     (PSLVERR_O),
  .LINE1_I       (LINE1_I),
  .LINE2_I       (LINE2_I),
  .EXPOSE_O      (EXPOSE_O),
  .WAITING_O     (WAITING_O),
  .FRAME_START_O (FRAME_START_O),
  .IRQ_O         (IRQ_O)
);
